// ===== src/elc_pkg.sv
//----------------------------------------------------------------------
// Exterior lamp controller package
//----------------------------------------------------------------------
// Purpose: Shared constants, pin and lamp carriers for the controller
// Assumes: 40 MHz system clock, 10 ms timer tick from a prescaler
// Notes:   All timers count ticks, not clock cycles
//
// Summary of operation
// RL1: Faulty indicator bulb doubles that side's rate
// RL2: Hazard drives both sides' indicators together
// RL3: Each hazard touch toggles hazard flashing
// RL4: Turn selection during hazard shows turn flashing
// RL5: Turn cancelled or ignition off resumes hazard
// RL6: Hazard touch replaces turn; next touch restores
// RL7: Network hazard request flashes at least 5 s
// RL8: Collision starts latched continuous hazard flashing
// RL9: Crash hazard cancelled only by 5 s hold
// RL10: Inertia release latches hazard; reset won't stop
// RL11: Rear fog needs ignition, head/front fog, switch
// RL12: Rear fog stays on through cranking
// RL13: Marker knob drives shared marker/tail/plate output
// RL14: Key out with lever keeps side parking lamps
// RL15: Dipped beam needs headlight knob and ignition
// RL16: Main beam latches with dipped, knob off clears
// RL17: Lever pulled flashes headlights while held
// RL18: Cold start cuts main beam while cranking
// RL19: Position lamp holds selection and 0-5 min delay
// RL20: Dark unlock lights selection; key/knob change cancels
// RL21: Front fog needs marker/head knob and ignition on
// RL22: Front fog shed during engine cranking
// RL23: Turn flashing at accessory or beyond, equal halves
// RL24: Flash and timers derive from a clock prescaler
//----------------------------------------------------------------------

package elc_pkg;

  //--------------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 10;
  localparam int FLASH_HALF_MS = 400;
  localparam int FLASH_HALF_TICKS = FLASH_HALF_MS / TICK_MS;
  localparam int FLASH_FAST_TICKS = FLASH_HALF_TICKS / 2;
  localparam int HOLD_S = 5;
  localparam int HOLD_TICKS = HOLD_S * 1000 / TICK_MS;
  localparam int CAN_HAZ_S = 5;
  localparam int CAN_TICKS = CAN_HAZ_S * 1000 / TICK_MS;
  localparam int STEP_S = 30;
  localparam int STEP_TICKS = STEP_S * 1000 / TICK_MS;
  localparam int MAX_STEPS = 10;
  localparam int POS_W = 15;
  localparam int HZC_W = 10;
  localparam int FLC_W = 6;

  //--------------------------------------------------------------------
  // Register map
  //--------------------------------------------------------------------
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_STEPS_LSB = 4;
  localparam logic [1:0] CFG_SEL_RESET = 2'h0;
  localparam logic [3:0] CFG_STEPS_RESET = 4'h0;

  //--------------------------------------------------------------------
  // Types
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {IGN_OFF, IGN_ACC, IGN_ON, IGN_CRANK} elc_ign_e;
  typedef enum logic [1:0] {KNOB_OFF, KNOB_MARKER, KNOB_HEAD} elc_knob_e;
  typedef enum logic [1:0] {FM_OFF, FM_TURN, FM_HAZ} elc_flash_e;

  typedef struct packed {
    logic key_in;
    elc_ign_e ign;
    elc_knob_e knob;
    logic turn_l;
    logic turn_r;
    logic lever_main;
    logic lever_flash;
    logic haz_sw;
    logic can_haz;
    logic collision;
    logic inertia_rel;
    logic fault_l;
    logic fault_r;
    logic ff_sw;
    logic rf_sw;
    logic engine_run;
    logic amb_low;
    logic unlock;
  } elc_pins_s;

  typedef struct packed {
    logic ind_l;
    logic ind_r;
    logic marker;
    logic park_l;
    logic park_r;
    logic panel;
    logic dipped;
    logic main;
    logic front_fog;
    logic ff_ind;
    logic rear_fog;
  } elc_lamps_s;

endpackage

// ===== src/elc_top.sv
//----------------------------------------------------------------------
// Exterior lamp controller
//----------------------------------------------------------------------
// Purpose: Indicator/hazard arbitration and exterior lamp switching
// Assumes: All pins asynchronous; register port on clock_i
// Notes:   Lamp outputs are registered, one cycle after their cause
//----------------------------------------------------------------------
`timescale 1ns/1ps

module elc_top
  import elc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC // Shorten for simulation
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire elc_pins_s pins_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output elc_lamps_s lamps_o
);

  //--------------------------------------------------------------------
  // Pin synchroniser
  //--------------------------------------------------------------------
  elc_pins_s sync1_r; // First stage, read only by sync2_r
  elc_pins_s sync2_r; // Safe copy of pins
  elc_pins_s prev_r; // Last cycle's copy, for edges

  // Two flops on every pin before any logic
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  elc_pins_s s;
  assign s = sync2_r;
  // Edge strobes
  logic haz_rise, can_rise, unlock_rise, turn_any, turn_rise, key_fall;
  assign haz_rise = s.haz_sw & ~prev_r.haz_sw;
  assign can_rise = s.can_haz & ~prev_r.can_haz;
  assign unlock_rise = s.unlock & ~prev_r.unlock;
  assign turn_any = s.turn_l | s.turn_r;
  assign turn_rise = turn_any & ~(prev_r.turn_l | prev_r.turn_r);
  assign key_fall = ~s.key_in & prev_r.key_in;

  //--------------------------------------------------------------------
  // Register port
  //--------------------------------------------------------------------
  logic [1:0] sel_r, sel_nxt; // Position lamp selection
  logic [3:0] steps_r, steps_nxt; // Off delay in 30 s steps
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] stat_w;

  // Decode writes and build the read word
  always_comb begin
    sel_nxt = sel_r;
    steps_nxt = steps_r;
    rdata_nxt = 32'h0;
    if (wr_i && addr_i == REG_CFG) begin
      sel_nxt = wdata_i[CFG_SEL_LSB +: 2]; // RL19
      // Clamp so the delay never exceeds five minutes
      if (wdata_i[CFG_STEPS_LSB +: 4] > 4'(MAX_STEPS)) begin
        steps_nxt = 4'(MAX_STEPS);
      end else begin
        steps_nxt = wdata_i[CFG_STEPS_LSB +: 4]; // RL19
      end
    end
    if (rd_i) begin
      unique case (addr_i)
        REG_CFG: begin
          rdata_nxt[CFG_SEL_LSB +: 2] = sel_r;
          rdata_nxt[CFG_STEPS_LSB +: 4] = steps_r;
        end
        REG_STAT: rdata_nxt = stat_w;
        default: rdata_nxt = 32'h0; // Unmapped reads zero
      endcase
    end
  end

  // Register the configuration and read data
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sel_r <= CFG_SEL_RESET;
      steps_r <= CFG_STEPS_RESET;
      rdata_r <= 32'h0;
    end else begin
      sel_r <= sel_nxt;
      steps_r <= steps_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata_o = rdata_r;

  //--------------------------------------------------------------------
  // Tick prescaler
  //--------------------------------------------------------------------
  logic [18:0] pre_r, pre_nxt;
  logic tick;

  // One tick per 10 ms of clock
  always_comb begin
    tick = (pre_r == 19'(TICK_CYCLES - 1));
    pre_nxt = tick ? 19'h0 : pre_r + 19'h1; // RL24
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pre_r <= 19'h0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Hazard and indicator arbitration
  //--------------------------------------------------------------------
  logic haz_on_r, haz_on_nxt; // Switch-owned hazard
  logic haz_pri_r, haz_pri_nxt; // Hazard wins over turn
  logic crash_r, crash_nxt; // Latched crash hazard
  logic [HZC_W-1:0] hold_r, hold_nxt; // Switch hold time
  logic [HZC_W-1:0] can_r, can_nxt; // Network hazard time left
  logic [FLC_W-1:0] flc_r, flc_nxt; // Flash half-period count
  logic phase_r, phase_nxt; // Lamp phase, on when set
  logic turn_ok, haz_act, fault_sel;
  logic [FLC_W-1:0] half_w;
  elc_flash_e mode_w;

  always_comb begin
    haz_on_nxt = haz_on_r;
    haz_pri_nxt = haz_pri_r;
    crash_nxt = crash_r;
    hold_nxt = hold_r;
    can_nxt = can_r;
    flc_nxt = flc_r;
    phase_nxt = phase_r;
    // Turn flashing needs accessory or beyond
    turn_ok = turn_any && s.ign != IGN_OFF; // RL23 RL5
    haz_act = haz_on_r | crash_r | (can_r != '0);
    if (turn_ok && !(haz_act && haz_pri_r)) begin
      mode_w = FM_TURN; // RL4
    end else if (haz_act) begin
      mode_w = FM_HAZ; // RL5
    end else begin
      mode_w = FM_OFF;
    end
    fault_sel = (s.turn_l & s.fault_l) | (s.turn_r & s.fault_r);
    if (mode_w == FM_TURN && fault_sel) begin
      half_w = FLC_W'(FLASH_FAST_TICKS); // RL1
    end else begin
      half_w = FLC_W'(FLASH_HALF_TICKS); // RL23
    end
    // Touch handling; crash latch ignores short touches
    if (haz_rise && !crash_r) begin
      haz_on_nxt = ~haz_on_r; // RL3
      haz_pri_nxt = ~haz_on_r; // RL6
    end
    // A fresh turn selection takes over from hazard
    if (turn_rise) begin
      haz_pri_nxt = 1'b0; // RL4
    end
    // Hold timer for cancelling the crash latch
    if (!s.haz_sw) begin
      hold_nxt = '0;
    end else if (tick && hold_r != HZC_W'(HOLD_TICKS)) begin
      hold_nxt = hold_r + HZC_W'(1);
    end
    if (crash_r && hold_r == HZC_W'(HOLD_TICKS)) begin
      crash_nxt = 1'b0; // RL9
      haz_on_nxt = 1'b0;
    end
    // New crash events win over the cancel
    if (s.collision || (s.inertia_rel && !prev_r.inertia_rel)) begin
      crash_nxt = 1'b1; // RL8 RL10
      haz_pri_nxt = 1'b1;
    end
    // Network request restarts its minimum time
    if (can_rise) begin
      can_nxt = HZC_W'(CAN_TICKS); // RL7
      haz_pri_nxt = 1'b1;
    end else if (tick && can_r != '0) begin
      can_nxt = can_r - HZC_W'(1);
    end
    // Equal on and off halves; restart lit when idle
    if (mode_w == FM_OFF) begin
      flc_nxt = '0;
      phase_nxt = 1'b1;
    end else if (tick) begin
      if (flc_r >= half_w - FLC_W'(1)) begin
        flc_nxt = '0;
        phase_nxt = ~phase_r; // RL23 RL24
      end else begin
        flc_nxt = flc_r + FLC_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      haz_on_r <= 1'b0;
      haz_pri_r <= 1'b0;
      crash_r <= 1'b0;
      hold_r <= '0;
      can_r <= '0;
      flc_r <= '0;
      phase_r <= 1'b1;
    end else begin
      haz_on_r <= haz_on_nxt;
      haz_pri_r <= haz_pri_nxt;
      crash_r <= crash_nxt;
      hold_r <= hold_nxt;
      can_r <= can_nxt;
      flc_r <= flc_nxt;
      phase_r <= phase_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Exterior lamps
  //--------------------------------------------------------------------
  logic main_r, main_nxt; // Main beam latch
  logic cold_r, cold_nxt; // Engine was off at ignition on
  logic park_l_r, park_l_nxt, park_r_r, park_r_nxt;
  logic [POS_W-1:0] pos_r, pos_nxt; // Position lamp time left
  logic pos_mark_r, pos_mark_nxt; // Markers lit at arming
  elc_lamps_s lamps_r, lamps_nxt;
  logic ign_on, crank, head, ff_req, pos_act;
  logic [3:0] steps_w;

  always_comb begin
    main_nxt = main_r;
    cold_nxt = cold_r;
    park_l_nxt = park_l_r;
    park_r_nxt = park_r_r;
    pos_nxt = pos_r;
    pos_mark_nxt = pos_mark_r;
    lamps_nxt = '0;
    steps_w = steps_r;
    crank = (s.ign == IGN_CRANK);
    ign_on = (s.ign == IGN_ON) || crank;
    head = (s.knob == KNOB_HEAD) && ign_on; // RL15
    ff_req = s.ff_sw && s.knob != KNOB_OFF && ign_on; // RL21
    pos_act = (pos_r != '0);
    // Capture a cold start when ignition comes on
    if (ign_on && !(prev_r.ign == IGN_ON || prev_r.ign == IGN_CRANK)) begin
      cold_nxt = ~s.engine_run; // RL18
    end
    // Main latch: set with dipped on, cleared by knob off
    if (s.knob == KNOB_OFF) begin
      main_nxt = 1'b0; // RL16
    end else if (head && s.lever_main) begin
      main_nxt = 1'b1; // RL16
    end
    // Parking side chosen as key leaves; lever off ends it
    if (key_fall) begin
      park_l_nxt = s.turn_l; // RL14
      park_r_nxt = s.turn_r;
    end
    if (!s.turn_l) park_l_nxt = 1'b0;
    if (!s.turn_r) park_r_nxt = 1'b0;
    // Position lamp timer
    if (unlock_rise && s.amb_low && sel_r != 2'h0) begin
      pos_nxt = POS_W'(int'(steps_w) * STEP_TICKS); // RL20
      pos_mark_nxt = (s.knob != KNOB_OFF);
    end else if (s.key_in != prev_r.key_in || s.ign != prev_r.ign ||
                 s.knob != prev_r.knob) begin
      pos_nxt = '0; // RL20
    end else if (tick && pos_act) begin
      pos_nxt = pos_r - POS_W'(1);
    end
    // Indicators
    unique case (mode_w)
      FM_TURN: begin
        lamps_nxt.ind_l = s.turn_l & phase_r; // RL23
        lamps_nxt.ind_r = s.turn_r & phase_r;
      end
      FM_HAZ: begin
        lamps_nxt.ind_l = phase_r; // RL2
        lamps_nxt.ind_r = phase_r; // RL2
      end
      FM_OFF: begin
        lamps_nxt.ind_l = 1'b0;
        lamps_nxt.ind_r = 1'b0;
      end
    endcase
    lamps_nxt.marker = (s.knob != KNOB_OFF) | (pos_act & pos_mark_r); // RL13
    lamps_nxt.park_l = park_l_r; // RL14
    lamps_nxt.park_r = park_r_r;
    // Panel stays dark while only parking lamps are lit
    lamps_nxt.panel = (s.knob != KNOB_OFF); // RL14
    lamps_nxt.dipped = head | (pos_act & sel_r[0]); // RL15 RL20
    lamps_nxt.main = ((main_r & head) | s.lever_flash) &
                     ~(crank & cold_r); // RL17 RL18
    lamps_nxt.front_fog = ff_req & ~crank; // RL22
    lamps_nxt.ff_ind = ff_req & ~crank; // RL21
    // Rear fog is not shed while cranking
    lamps_nxt.rear_fog = (ign_on & (head | ff_req) & s.rf_sw) |
                         (pos_act & sel_r[1]); // RL11 RL12
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      main_r <= 1'b0;
      cold_r <= 1'b0;
      park_l_r <= 1'b0;
      park_r_r <= 1'b0;
      pos_r <= '0;
      pos_mark_r <= 1'b0;
      lamps_r <= '0;
    end else begin
      main_r <= main_nxt;
      cold_r <= cold_nxt;
      park_l_r <= park_l_nxt;
      park_r_r <= park_r_nxt;
      pos_r <= pos_nxt;
      pos_mark_r <= pos_mark_nxt;
      lamps_r <= lamps_nxt;
    end
  end
  assign lamps_o = lamps_r;

  // Status word for software
  assign stat_w = {24'h0, pos_act, cold_r, main_r, crash_r, (can_r != '0),
                   haz_on_r, mode_w};

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_fast_rate; // Fault half count stays below the fast span
    (mode_w == FM_TURN && fault_sel && tick) |=>
      flc_r < FLC_W'(FLASH_FAST_TICKS);
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("slow fault"); // RL1

  property p_haz_both;
    (mode_w == FM_HAZ) |=> (lamps_o.ind_l == lamps_o.ind_r);
  endproperty
  a_haz_both: assert property (p_haz_both) else $error("haz split"); // RL2

  property p_touch;
    (haz_rise && !crash_r && !s.collision) |=> (haz_on_r != $past(haz_on_r));
  endproperty
  a_touch: assert property (p_touch) else $error("no toggle"); // RL3

  property p_turn_over;
    (haz_on_r && turn_rise && s.ign != IGN_OFF && !can_rise &&
     !s.collision && !s.inertia_rel) |=> ##1 (mode_w == FM_TURN || !turn_ok);
  endproperty
  a_turn_over: assert property (p_turn_over) else $error("no turn"); // RL4

  property p_can_load;
    can_rise |=> (can_r == HZC_W'(CAN_TICKS)) ##1 (mode_w != FM_OFF);
  endproperty
  a_can_load: assert property (p_can_load) else $error("can time"); // RL7

  property p_crash_hold;
    (crash_r && hold_r != HZC_W'(HOLD_TICKS)) |=> crash_r;
  endproperty
  a_crash_hold: assert property (p_crash_hold) else $error("crash off"); // RL9

  property p_rear_fog;
    (!ign_on && !pos_act) |=> !lamps_o.rear_fog;
  endproperty
  a_rear_fog: assert property (p_rear_fog) else $error("rear fog"); // RL11

  property p_ff_shed;
    crank |=> !lamps_o.front_fog;
  endproperty
  a_ff_shed: assert property (p_ff_shed) else $error("ff on crank"); // RL22

  property p_main_shed;
    (crank && cold_r) |=> !lamps_o.main;
  endproperty
  a_main_shed: assert property (p_main_shed) else $error("main crank"); // RL18

  property p_dipped;
    (!head && !pos_act) |=> !lamps_o.dipped;
  endproperty
  a_dipped: assert property (p_dipped) else $error("dipped"); // RL15

  c_crash: cover property (s.collision ##1 crash_r);
  c_can: cover property (can_rise ##1 mode_w == FM_HAZ);
  c_pos: cover property (unlock_rise ##1 pos_act);
  c_fault: cover property (mode_w == FM_TURN && fault_sel);

endmodule // elc_top

// ===== tb/elc_partner.sv
//--------------------
// Switch and lamp side model
//--------------------
// Purpose: Drives the controller pins from bench commands
// Assumes: Commands change just after a rising edge
// Notes:   Broken bulbs show as fault levels from the monitor
`timescale 1ns/1ps

module elc_partner
  import elc_pkg::*;
(
  input wire logic clock_i,
  input wire elc_pins_s cmd_i,
  input wire logic open_l_i, // Left bulb broken
  input wire logic open_r_i, // Right bulb broken
  output elc_pins_s pins_o
);
  elc_pins_s pins_nxt; // Switch levels merged with bulb monitor

  // Bulb monitor reports a broken bulb as a steady fault level
  always_comb begin
    pins_nxt = cmd_i;
    pins_nxt.fault_l = open_l_i;
    pins_nxt.fault_r = open_r_i;
  end

  // Switch bank settles on an edge, never mid-cycle
  always_ff @(posedge clock_i) begin
    pins_o <= pins_nxt;
  end
endmodule // elc_partner

// ===== tb/exterior_lamp_controller_test.sv
//--------------------
// Lamp controller testbench
//--------------------
// Purpose: Table of lamp cases, then flasher and timer cases
// Assumes: Short tick of 4 cycles; all timers scale from it
// Notes:   Flash halves are measured in cycles
`timescale 1ns/1ps

module exterior_lamp_controller_test
  import elc_pkg::*;
();
  localparam int TK = 4; // Short tick keeps the run brief
  localparam int HALF = FLASH_HALF_TICKS * TK; // Normal half
  localparam int FAST = FLASH_FAST_TICKS * TK; // Faulty bulb half
  localparam int HOLD = HOLD_TICKS * TK; // Crash cancel hold
  localparam int NET = CAN_TICKS * TK; // Network hazard span
  localparam int STEP = STEP_TICKS * TK; // One delay step

  // One lamp case: inputs, expected {marker,dipped,ff,ff_ind,rf}
  typedef struct packed {
    elc_ign_e ign;
    elc_knob_e knob;
    logic ff;
    logic rf;
    logic [4:0] exp;
    logic [4:0] msk;
  } elc_row_s;

  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  elc_pins_s cmd = '0; // Commanded switch levels
  elc_pins_s pins;
  logic open_l = 1'b0;
  logic open_r = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata_o;
  elc_lamps_s lamps_o;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] rv; // Read data
  logic [2:0] s; // {left seen, right seen, sides differed}
  int n; // Measured half length
  elc_row_s rows [7];

  elc_partner u_far (.clock_i(clock_i), .cmd_i(cmd),
    .open_l_i(open_l), .open_r_i(open_r), .pins_o(pins));

  elc_top #(.TICK_CYCLES(TK)) u_dut (.clock_i(clock_i),
    .reset_i(reset_i), .pins_i(pins), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata_o), .lamps_o(lamps_o));

  // 40 MHz clock
  always #12.5 clock_i = ~clock_i;

  //--------------------
  // Helpers
  //--------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h",
        $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Trailing idle cycle so the next strobe never lands in this step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
    @(posedge clock_i);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
    @(posedge clock_i);
  endtask

  function automatic logic ind(input bit r);
    return r ? lamps_o.ind_r : lamps_o.ind_l;
  endfunction

  // Window longer than a full flash period shows the flash mode
  task automatic watch(input int k, output logic [2:0] v);
    v = 3'b000;
    repeat (k) begin
      @(negedge clock_i);
      v[2] = v[2] | lamps_o.ind_l;
      v[1] = v[1] | lamps_o.ind_r;
      v[0] = v[0] | (lamps_o.ind_l !== lamps_o.ind_r);
    end
    @(posedge clock_i);
  endtask

  // Length of one whole dark half, bounded waits throughout
  task automatic half(input bit r, output int k);
    repeat (400) begin
      @(negedge clock_i);
      if (ind(r) === 1'b1) break;
    end
    repeat (400) begin
      @(negedge clock_i);
      if (ind(r) !== 1'b1) break;
    end
    k = 0;
    while (ind(r) !== 1'b1 && k < 400) begin
      @(negedge clock_i);
      k++;
    end
    @(posedge clock_i);
  endtask

  task automatic touch(input int k);
    cmd.haz_sw <= 1'b1;
    cyc(k);
    cmd.haz_sw <= 1'b0;
    cyc(8);
  endtask

  task automatic set_turn(input bit l, input bit r);
    cmd.turn_l <= l;
    cmd.turn_r <= r;
    cyc(8);
  endtask

  // Latched hazard from a crash source, short touch, long hold
  task automatic crash(input bit inertia);
    if (inertia) cmd.inertia_rel <= 1'b1;
    else cmd.collision <= 1'b1;
    cyc(8);
    cmd.inertia_rel <= 1'b0;
    cmd.collision <= 1'b0;
    cyc(8);
    watch(400, s);
    check(32'(s), 32'h6);
    rd(REG_STAT, rv);
    check(rv & 32'h1f, 32'h12);
    touch(100);
    watch(400, s);
    check(32'(s), 32'h6);
    touch(HOLD + 40);
    watch(400, s);
    check(32'(s), 32'h0);
    $display("crash case done");
  endtask

  //--------------------
  // Main sequence
  //--------------------
  initial begin
    rows = '{'{IGN_ACC, KNOB_MARKER, 1'b1, 1'b1, 5'h10, 5'h1f},
      '{IGN_ON, KNOB_MARKER, 1'b1, 1'b1, 5'h17, 5'h1f},
      '{IGN_ON, KNOB_MARKER, 1'b0, 1'b1, 5'h10, 5'h1f},
      '{IGN_ON, KNOB_HEAD, 1'b1, 1'b1, 5'h0f, 5'h0f},
      '{IGN_CRANK, KNOB_HEAD, 1'b1, 1'b1, 5'h01, 5'h07},
      '{IGN_ON, KNOB_OFF, 1'b1, 1'b1, 5'h00, 5'h1f},
      '{IGN_OFF, KNOB_HEAD, 1'b1, 1'b1, 5'h00, 5'h0f}};
    cyc(9);
    @(negedge clock_i);
    check(32'(lamps_o), 32'h0);
    check(rdata_o, 32'h0);
    @(posedge clock_i);
    reset_i <= 1'b0;
    cyc(4);
    // Config reset value, unmapped place, step clamp
    rd(REG_CFG, rv);
    check(rv, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, rv);
    check(rv, 32'h0);
    rd(REG_CFG, rv);
    check(rv, 32'h0);
    wr(REG_CFG, 32'h0000_00f1);
    rd(REG_CFG, rv);
    check(rv, 32'h0000_00a1);
    wr(REG_CFG, 32'h0000_0011);
    rd(REG_CFG, rv);
    check(rv, 32'h0000_0011);
    $display("register case done");
    // Table of steady lamp cases; crank row follows an ON row
    cmd.key_in <= 1'b1;
    foreach (rows[i]) begin
      cmd.ign <= rows[i].ign;
      cmd.knob <= rows[i].knob;
      cmd.ff_sw <= rows[i].ff;
      cmd.rf_sw <= rows[i].rf;
      cyc(8);
      check(32'({lamps_o.marker, lamps_o.dipped, lamps_o.front_fog,
        lamps_o.ff_ind, lamps_o.rear_fog} & rows[i].msk),
        32'(rows[i].exp));
    end
    cmd.knob <= KNOB_OFF;
    cmd.ff_sw <= 1'b0;
    cmd.rf_sw <= 1'b0;
    $display("lamp table done");
    // Hazard toggles, both sides together
    touch(4);
    watch(400, s);
    check(32'(s), 32'h6);
    half(1'b0, n);
    check(32'(n), 32'(HALF));
    touch(4);
    watch(400, s);
    check(32'(s), 32'h0);
    // Turn with a broken bulb, then repaired
    cmd.ign <= IGN_ACC;
    open_l <= 1'b1;
    set_turn(1'b1, 1'b0);
    half(1'b0, n);
    check(32'(n), 32'(FAST));
    watch(400, s);
    check(32'(s), 32'h5);
    open_l <= 1'b0;
    cyc(8);
    half(1'b0, n);
    check(32'(n), 32'(HALF));
    $display("flash rate case done");
    // Turn and hazard priorities
    set_turn(1'b0, 1'b0);
    touch(4);
    set_turn(1'b0, 1'b1);
    watch(400, s);
    check(32'(s), 32'h3);
    set_turn(1'b0, 1'b0);
    watch(400, s);
    check(32'(s), 32'h6);
    touch(4);
    set_turn(1'b0, 1'b1);
    touch(4);
    watch(400, s);
    check(32'(s), 32'h6);
    touch(4);
    watch(400, s);
    check(32'(s), 32'h3);
    set_turn(1'b0, 1'b0);
    touch(4);
    set_turn(1'b0, 1'b1);
    cmd.ign <= IGN_OFF;
    cyc(8);
    watch(400, s);
    check(32'(s), 32'h6);
    touch(4);
    set_turn(1'b0, 1'b0);
    $display("priority case done");
    // Network request runs its full span, then stops
    cmd.can_haz <= 1'b1;
    cyc(4);
    cmd.can_haz <= 1'b0;
    cyc(NET - 400);
    watch(200, s);
    check(32'(s), 32'h6);
    cyc(300);
    watch(400, s);
    check(32'(s), 32'h0);
    $display("network case done");
    crash(1'b0);
    crash(1'b1);
    // Main beam latch, flash, cold-start shed
    cmd.engine_run <= 1'b1;
    cmd.ign <= IGN_ON;
    cmd.knob <= KNOB_HEAD;
    cyc(8);
    cmd.lever_main <= 1'b1;
    cyc(8);
    cmd.lever_main <= 1'b0;
    cyc(8);
    check(32'(lamps_o.main), 32'h1);
    cmd.knob <= KNOB_OFF;
    cyc(8);
    check(32'(lamps_o.main), 32'h0);
    cmd.lever_flash <= 1'b1;
    cyc(8);
    check(32'(lamps_o.main), 32'h1);
    cmd.lever_flash <= 1'b0;
    cmd.ign <= IGN_OFF;
    cmd.engine_run <= 1'b0;
    cyc(8);
    check(32'(lamps_o.main), 32'h0);
    cmd.ign <= IGN_ON;
    cmd.knob <= KNOB_HEAD;
    cmd.lever_main <= 1'b1;
    cyc(8);
    cmd.lever_main <= 1'b0;
    cyc(8);
    check(32'(lamps_o.main), 32'h1);
    cmd.ign <= IGN_CRANK;
    cyc(8);
    check(32'(lamps_o.main), 32'h0);
    cmd.ign <= IGN_OFF;
    cmd.knob <= KNOB_OFF;
    $display("beam case done");
    // Key out with lever set keeps one side lit
    set_turn(1'b1, 1'b0);
    cmd.key_in <= 1'b0;
    cyc(8);
    check(32'({lamps_o.park_l, lamps_o.park_r, lamps_o.panel}),
      32'h4);
    set_turn(1'b0, 1'b0);
    check(32'({lamps_o.park_l, lamps_o.park_r}), 32'h0);
    // Dark unlock lights dipped only, for one step
    cmd.amb_low <= 1'b1;
    cmd.unlock <= 1'b1;
    cyc(8);
    cmd.unlock <= 1'b0;
    cyc(STEP - 1000);
    check(32'({lamps_o.dipped, lamps_o.rear_fog}), 32'h2);
    cyc(1100);
    check(32'({lamps_o.dipped, lamps_o.rear_fog}), 32'h0);
    cmd.unlock <= 1'b1;
    cyc(8);
    cmd.unlock <= 1'b0;
    cyc(8);
    check(32'({lamps_o.dipped, lamps_o.rear_fog}), 32'h2);
    cmd.knob <= KNOB_MARKER;
    cyc(8);
    check(32'({lamps_o.dipped, lamps_o.rear_fog}), 32'h0);
    $display("position case done");
    end_sim();
  end

  // Watchdog: about twice the expected run
  initial begin
    repeat (60000) @(posedge clock_i);
    num_errors++;
    end_sim();
  end
endmodule // exterior_lamp_controller_test
